//--- dv/acq_analog_control_regs_asserts.sv
`default_nettype none
// -------------
// Port checks
// -------------
module acq_analog_control_regs_asserts (
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       spi_cs_n_i,
    input wire logic       spi_miso_o,
    input wire logic       spi_miso_oe_o,
    input wire logic       second_normal_monitor_mode_i,
    input wire logic       sample_valid_i,
    input wire logic       irq_ack_i,
    input wire logic       irq_o,
    input wire logic [1:0] current_gain_sel_o,
    input wire logic [1:0] voltage_gain_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Reset checks must run while reset is high, so they opt out of the disable
    a_rst_gain: assert property (disable iff (1'b0) sys_rst_i |=>
        {current_gain_sel_o, voltage_gain_sel_o} == 4'h5) else $error("gain reset");
    a_rst_irq: assert property (disable iff (1'b0) sys_rst_i |=> !irq_o)
        else $error("irq reset");
    // Eight idle cycles leave no write in flight, so gains must hold
    a_gain_idle: assert property (spi_cs_n_i [*8] |=>
        $stable({current_gain_sel_o, voltage_gain_sel_o})) else $error("gain moved");
    a_irq_mode: assert property (!second_normal_monitor_mode_i |=> !irq_o)
        else $error("irq outside mode");
    a_irq_cause: assert property ($rose(irq_o) |->
        $past(sample_valid_i) || $past(sample_valid_i, 2)) else $error("irq uncaused");
    a_irq_hold: assert property (irq_o && !irq_ack_i &&
        second_normal_monitor_mode_i |=> irq_o) else $error("irq dropped");
    a_irq_ack: assert property (irq_o && irq_ack_i && !sample_valid_i &&
        !$past(sample_valid_i) |=> !irq_o) else $error("ack ignored");
    a_miso_idle: assert property (spi_cs_n_i [*5] |->
        !spi_miso_oe_o && !spi_miso_o) else $error("miso driven idle");
    // Selection must turn the data line on once the select has crossed over
    a_oe_select: assert property (!spi_cs_n_i [*3] |=> spi_miso_oe_o)
        else $error("miso not driven");
    // Main scenarios
    c_irq: cover property ($rose(irq_o));
    c_ack: cover property (irq_o && irq_ack_i);
    c_gain: cover property (!$stable(current_gain_sel_o));
endmodule

bind acq_analog_control_regs acq_analog_control_regs_asserts acq_analog_control_regs_asserts_i (.*);
`default_nettype wire

//--- dv/acq_analog_control_regs_test.sv
`default_nettype none
module acq_analog_control_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    // -------------
    // Bench
    // -------------
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        mode = 1'b0, s_valid = 1'b0, ack = 1'b0;
    logic [15:0] s_data = 16'h0000;
    logic [7:0]  r;
    wire         sclk, cs_n, mosi, miso, irq;
    wire  [9:0]  ctl;
    int          err_count = 0, n_checks = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    acq_analog_control_regs acq_analog_control_regs_i (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(), .second_normal_monitor_mode_i(mode),
        .sample_valid_i(s_valid), .sample_i(s_data), .irq_ack_i(ack), .irq_o(irq),
        .current_gain_sel_o(ctl[9:8]), .voltage_gain_sel_o(ctl[7:6]),
        .current_chop_clk_en_o(ctl[5]), .voltage_chop_clk_en_o(ctl[4]),
        .current_pga_en_o(ctl[3]), .current_modulator_en_o(ctl[2]),
        .voltage_pga_en_o(ctl[1]), .voltage_modulator_en_o(ctl[0]));
    spi_host_model spi_host_model_i (.ref_clk_i(ref_clk_i), .miso_i(miso),
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    task automatic chk(input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi_host_model_i.xfer({1'b1, a, d}, 16, 4, r);
    endtask
    task automatic rc(input logic [6:0] a, input logic [7:0] exp);
        spi_host_model_i.xfer({1'b0, a, 8'h00}, 16, 4, r);
        chk(16'(r), 16'(exp));
    endtask
    // One sample pulse, then room for the flag to settle
    task automatic smp(input logic [15:0] v);
        @(posedge ref_clk_i);
        s_valid <= 1'b1;
        s_data <= v;
        @(posedge ref_clk_i);
        s_valid <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    // Reset values, distinct bytes, reserved bits, unmapped places
    task automatic t_regs;
        logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'hCF};
        logic [7:0] mk [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'hCF};
        chk(16'(ctl), 16'h017F);
        for (int i = 0; i < 6; i++) begin
            rc(7'(15 + i), rv[i]);
            wr(7'(15 + i), 8'(8'hA5 + i));
        end
        for (int i = 0; i < 6; i++) rc(7'(15 + i), 8'(8'hA5 + i) & mk[i]);
        wr(7'h0E, 8'hFF);
        rc(7'h0E, 8'h00);
        rc(7'h15, 8'h00);
        $display("Register map test done");
    endtask
    // Every gain code; each power bit alone and knocked out
    task automatic t_ctl;
        logic [7:0] p;
        for (int i = 0; i < 16; i++) begin
            p = (i < 8) ? 8'(1 << i) : ~8'(1 << (i - 8));
            wr(7'h13, {4'(i), 4'hF});
            wr(7'h14, p);
            rc(7'h14, p & 8'hCF);
            chk(16'(ctl), 16'({4'(i), p[7:6], p[3:0]}));
        end
        // A cut frame must not write; a slow one still must
        spi_host_model_i.xfer({1'b1, 7'h13, 8'h00}, 12, 4, r);
        chk(16'(ctl[9:6]), 16'h000F);
        spi_host_model_i.xfer({1'b1, 7'h13, 8'h90}, 16, 7, r);
        chk(16'(ctl[9:6]), 16'h0009);
        $display("Control output test done");
    endtask
    // Skip count across both bytes, threshold edge, ack, mode exit
    task automatic t_irq;
        wr(7'h0F, 8'h01);
        wr(7'h10, 8'h02);
        wr(7'h11, 8'h12);
        wr(7'h12, 8'h34);
        mode <= 1'b1;
        for (int i = 0; i < 258; i++) smp(16'hFFFF);
        chk(16'(irq), 16'h0000);
        smp(16'h1234);
        chk(16'(irq), 16'h0000);
        smp(16'h1235);
        chk(16'(irq), 16'h0001);
        ack <= 1'b1;
        @(posedge ref_clk_i);
        ack <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk(16'(irq), 16'h0000);
        smp(16'h8000);
        chk(16'(irq), 16'h0001);
        mode <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk(16'(irq), 16'h0000);
        $display("Interrupt test done");
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        t_regs();
        t_ctl();
        t_irq();
        wrap_up();
    end
endmodule
`default_nettype wire

//--- dv/spi_host_model.sv
`default_nettype none
// -------------
// Serial host
// -------------
module spi_host_model (
    input  wire logic ref_clk_i,
    input  wire logic miso_i,
    output var  logic sclk_o,
    output var  logic cs_n_o,
    output var  logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {sclk_o, cs_n_o, mosi_o} = 3'b010;
    // First n bits MSB first, h clocks per half period; n below 16 aborts.
    // Read bits are taken late in the high phase, clear of the MISO change.
    task automatic xfer(input logic [15:0] f, input int n, h, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge ref_clk_i);
        cs_n_o <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            mosi_o <= f[i];
            repeat (h) @(posedge ref_clk_i);
            sclk_o <= 1'b1;
            repeat (h) @(posedge ref_clk_i);
            if (i < 8) rd[i] = miso_i;
            sclk_o <= 1'b0;
        end
        repeat (h) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o; // Deselected line must not keep the last bit
        repeat (10) @(posedge ref_clk_i);
    endtask
endmodule
`default_nettype wire

//--- inc/acq_analog_regs.vh
`ifndef ACQ_ANALOG_REGS_VH
`define ACQ_ANALOG_REGS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_SKIP_HIGH      7'h0F
`define ADDR_SKIP_LOW       7'h10
`define ADDR_THRESH_HIGH    7'h11
`define ADDR_THRESH_LOW     7'h12
`define ADDR_GAIN_CTRL      7'h13
`define ADDR_POWER_ONE      7'h14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SKIP_HIGH       8'h00
`define RST_SKIP_LOW        8'h00
`define RST_THRESH_HIGH     8'h00
`define RST_THRESH_LOW      8'h00
`define RST_GAIN_CTRL       8'h50
`define RST_POWER_ONE       8'hCF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GAIN_CUR_HI         7
`define GAIN_CUR_LO         6
`define GAIN_VOLT_HI        5
`define GAIN_VOLT_LO        4
`define PWR_CHOP_CUR        7
`define PWR_CHOP_VOLT       6
`define PWR_PGA_CUR         3
`define PWR_MOD_CUR         2
`define PWR_PGA_VOLT        1
`define PWR_MOD_VOLT        0

// ----------------------------------------------------------------
// Gain codes
// ----------------------------------------------------------------
`define GAIN_CODE_5         2'h0
`define GAIN_CODE_25        2'h1
`define GAIN_CODE_40        2'h2
`define GAIN_CODE_100       2'h3

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define FRAME_WRITE_BIT     15
`define FRAME_ADDR_HI       14
`define FRAME_ADDR_LO       8
`define FRAME_BITS          5'h10
`define FRAME_CMD_LAST      5'h07
`define FRAME_DATA_FIRST    5'h08
`define FRAME_LAST          5'h0F
`define SYNC_PINS           3

`endif

//--- rtl/acq_analog_control_regs.v
// What this block does
// R1 - Hold 16-bit sample skip count, two bytes
// R2 - Hold 16-bit second-mode current threshold bytes
// R3 - Current gain code: 5, 25, 40, 100
// R4 - Voltage gain code: 5, 25, 40
// R5 - Current chopper clock on when bit set
// R6 - Voltage chopper clock on when bit set
// R7 - Current amplifier powered when bit set
// R8 - Current modulator enabled when bit set
// R9 - Voltage amplifier powered when bit set
// R10 - Voltage modulator enabled when bit set
// R11 - Interrupt after skips and threshold crossing
`include "acq_analog_regs.vh"
`default_nettype none

module acq_analog_control_regs (
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    input  wire        spi_sclk_i,
    input  wire        spi_cs_n_i,
    input  wire        spi_mosi_i,
    output reg         spi_miso_o,
    output reg         spi_miso_oe_o,
    input  wire        second_normal_monitor_mode_i,
    input  wire        sample_valid_i,
    input  wire [15:0] sample_i,
    input  wire        irq_ack_i,
    output wire        irq_o,
    output reg  [1:0]  current_gain_sel_o,
    output reg  [1:0]  voltage_gain_sel_o,
    output reg         current_chop_clk_en_o,
    output reg         voltage_chop_clk_en_o,
    output reg         current_pga_en_o,
    output reg         current_modulator_en_o,
    output reg         voltage_pga_en_o,
    output reg         voltage_modulator_en_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [`SYNC_PINS-1:0] pin_raw;
    reg  [`SYNC_PINS-1:0] pin_meta_q;
    reg  [`SYNC_PINS-1:0] pin_sync_q;
    reg                   sclk_prev_q;

    assign pin_raw = {spi_sclk_i, spi_cs_n_i, spi_mosi_i};

    // Two flops per pin; only the second stage feeds logic
    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_PINS; gi = gi + 1) begin : g_sync
            always @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    pin_meta_q[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                    pin_sync_q[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                end else begin
                    pin_meta_q[gi] <= pin_raw[gi];
                    pin_sync_q[gi] <= pin_meta_q[gi];
                end
            end
        end
    endgenerate

    wire sclk_s = pin_sync_q[2];
    wire cs_n_s = pin_sync_q[1];
    wire mosi_s = pin_sync_q[0];
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s & sclk_prev_q;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [7:0] skip_high_q;
    reg [7:0] skip_low_q;
    reg [7:0] thresh_high_q;
    reg [7:0] thresh_low_q;
    reg [7:0] gain_ctrl_q;
    reg [7:0] power_one_q;

    // Reserved bits read back as zero
    wire [7:0] gain_rd  = {gain_ctrl_q[7:4], 4'h0};
    wire [7:0] power_rd = {power_one_q[7:6], 2'h0, power_one_q[3:0]};

    // ------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------
    reg [4:0]  bit_cnt_q;
    reg [15:0] shift_in_q;
    reg [7:0]  tx_q;
    reg [7:0]  rd_data;

    wire [15:0] frame_next = {shift_in_q[14:0], mosi_s};
    // At the 8th rise only eight bits are in, so the address is the low seven
    wire [6:0]  cmd_addr   = frame_next[`FRAME_ADDR_HI-`FRAME_ADDR_LO:0];
    wire [6:0]  wr_addr    = shift_in_q[`FRAME_ADDR_HI-1:`FRAME_ADDR_LO-1];
    wire        wr_strobe  = ~cs_n_s & sclk_rise & (bit_cnt_q == `FRAME_LAST) &
                             shift_in_q[`FRAME_WRITE_BIT-1];

    // Read decode; unmapped addresses read as zero
    always @* begin
        rd_data = 8'h00;
        if (cmd_addr[6:0] == `ADDR_SKIP_HIGH) begin
            rd_data = skip_high_q;
        end else if (cmd_addr == `ADDR_SKIP_LOW) begin
            rd_data = skip_low_q;
        end else if (cmd_addr == `ADDR_THRESH_HIGH) begin
            rd_data = thresh_high_q;
        end else if (cmd_addr == `ADDR_THRESH_LOW) begin
            rd_data = thresh_low_q;
        end else if (cmd_addr == `ADDR_GAIN_CTRL) begin
            rd_data = gain_rd;
        end else if (cmd_addr == `ADDR_POWER_ONE) begin
            rd_data = power_rd;
        end
    end

    // Mode 0: sample on rising edge, shift out on falling edge
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sclk_prev_q   <= 1'b0;
            bit_cnt_q     <= 5'h00;
            shift_in_q    <= 16'h0000;
            tx_q          <= 8'h00;
            spi_miso_o    <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else begin
            sclk_prev_q   <= sclk_s;
            spi_miso_oe_o <= ~cs_n_s;
            if (cs_n_s) begin
                // Deselect aborts a partial frame, so nothing is written
                bit_cnt_q  <= 5'h00;
                spi_miso_o <= 1'b0;
            end else if (sclk_rise && bit_cnt_q < `FRAME_BITS) begin
                shift_in_q <= frame_next;
                bit_cnt_q  <= bit_cnt_q + 5'h01;
                if (bit_cnt_q == `FRAME_CMD_LAST) begin
                    tx_q <= rd_data;
                end
            end else if (sclk_fall && bit_cnt_q >= `FRAME_DATA_FIRST &&
                         bit_cnt_q <= `FRAME_LAST) begin
                spi_miso_o <= tx_q[7];
                tx_q       <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            skip_high_q   <= `RST_SKIP_HIGH;
            skip_low_q    <= `RST_SKIP_LOW;
            thresh_high_q <= `RST_THRESH_HIGH;
            thresh_low_q  <= `RST_THRESH_LOW;
            gain_ctrl_q   <= `RST_GAIN_CTRL;
            power_one_q   <= `RST_POWER_ONE;
        end else if (wr_strobe) begin
            if (wr_addr == `ADDR_SKIP_HIGH) begin
                skip_high_q <= frame_next[7:0]; // R1
            end else if (wr_addr == `ADDR_SKIP_LOW) begin
                skip_low_q <= frame_next[7:0]; // R1
            end else if (wr_addr == `ADDR_THRESH_HIGH) begin
                thresh_high_q <= frame_next[7:0]; // R2
            end else if (wr_addr == `ADDR_THRESH_LOW) begin
                thresh_low_q <= frame_next[7:0]; // R2
            end else if (wr_addr == `ADDR_GAIN_CTRL) begin
                gain_ctrl_q <= {frame_next[7:4], 4'h0};
            end else if (wr_addr == `ADDR_POWER_ONE) begin
                power_one_q <= {frame_next[7:6], 2'h0, frame_next[3:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------
    // Registered so the analog side never sees decode glitches
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            current_gain_sel_o     <= `GAIN_CODE_25;
            voltage_gain_sel_o     <= `GAIN_CODE_25;
            current_chop_clk_en_o  <= 1'b1;
            voltage_chop_clk_en_o  <= 1'b1;
            current_pga_en_o       <= 1'b1;
            current_modulator_en_o <= 1'b1;
            voltage_pga_en_o       <= 1'b1;
            voltage_modulator_en_o <= 1'b1;
        end else begin
            current_gain_sel_o     <= gain_ctrl_q[`GAIN_CUR_HI:`GAIN_CUR_LO]; // R3
            // Code 11 has no defined voltage gain; passed through as written
            voltage_gain_sel_o     <= gain_ctrl_q[`GAIN_VOLT_HI:`GAIN_VOLT_LO]; // R4
            current_chop_clk_en_o  <= power_one_q[`PWR_CHOP_CUR]; // R5
            voltage_chop_clk_en_o  <= power_one_q[`PWR_CHOP_VOLT]; // R6
            current_pga_en_o       <= power_one_q[`PWR_PGA_CUR]; // R7
            current_modulator_en_o <= power_one_q[`PWR_MOD_CUR]; // R8
            voltage_pga_en_o       <= power_one_q[`PWR_PGA_VOLT]; // R9
            voltage_modulator_en_o <= power_one_q[`PWR_MOD_VOLT]; // R10
        end
    end

    // ------------------------------------------------------------
    // Second normal mode interrupt
    // ------------------------------------------------------------
    skip_threshold_irq u_irq (
        .ref_clk_i      (ref_clk_i),
        .sys_rst_i      (sys_rst_i),
        .mode_active_i  (second_normal_monitor_mode_i),
        .sample_valid_i (sample_valid_i),
        .sample_i       (sample_i),
        .skip_count_i   ({skip_high_q, skip_low_q}),
        .threshold_i    ({thresh_high_q, thresh_low_q}),
        .irq_ack_i      (irq_ack_i),
        .irq_o          (irq_o)
    );

endmodule
`default_nettype wire

//--- rtl/skip_threshold_irq.v
`include "acq_analog_regs.vh"
`default_nettype none

// ----------------------------------------------------------------
// Second normal mode: skip samples, then watch the threshold
// ----------------------------------------------------------------
module skip_threshold_irq (
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    input  wire        mode_active_i,
    input  wire        sample_valid_i,
    input  wire [15:0] sample_i,
    input  wire [15:0] skip_count_i,
    input  wire [15:0] threshold_i,
    input  wire        irq_ack_i,
    output reg         irq_o
);

    reg [15:0] skipped_q;
    reg        mode_q;

    // Counter restarts whenever the mode is (re)entered
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            skipped_q <= 16'h0000;
            mode_q    <= 1'b0;
        end else begin
            mode_q <= mode_active_i;
            if (!mode_active_i || !mode_q) begin
                skipped_q <= 16'h0000;
            end else if (sample_valid_i && skipped_q < skip_count_i) begin
                skipped_q <= skipped_q + 16'h0001; // R11
            end
        end
    end

    // Sticky flag; a crossing in the ack cycle wins over the ack
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else if (mode_active_i && mode_q && sample_valid_i &&
                     skipped_q >= skip_count_i && sample_i > threshold_i) begin
            irq_o <= 1'b1; // R11
        end else if (irq_ack_i || !mode_active_i) begin
            irq_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire
